// ### ppmc_consts.vh
// offsets, field positions, reset values and timing counts for ppmc
`ifndef PPMC_CONSTS_VH
`define PPMC_CONSTS_VH

// register map (byte addresses, each register one aligned word)
`define PPMC_PORT_STRIDE 12'h010
`define PPMC_PORT_FIRST 12'h010
`define PPMC_OFF_XOVER 4'h0
`define PPMC_OFF_PHYCTL 4'h4
`define PPMC_ADDR_MACCTL0 12'h100
`define PPMC_ADDR_MACCTL1 12'h104
`define PPMC_NUM_PHY 5

// cable_crossover_control fields
`define PPMC_XOVER_FORCED_STRAIGHT 7
`define PPMC_XOVER_DISABLE 6
`define PPMC_XOVER_RESET 16'h0000

// phy_jabber_and_link_result fields
`define PPMC_PHYCTL_JABBER 9
`define PPMC_PHYCTL_SPD1000 6
`define PPMC_PHYCTL_SPD100 5
`define PPMC_PHYCTL_SPD10 4
`define PPMC_PHYCTL_DUPLEX 3
`define PPMC_PHYCTL_MASTER 2
`define PPMC_PHYCTL_RW_MASK 16'hF382
`define PPMC_PHYCTL_RESET 16'h0300

// resolved speed codes from the phy core
`define PPMC_SPD_CODE_10 2'h0
`define PPMC_SPD_CODE_100 2'h1
`define PPMC_SPD_CODE_1000 2'h2

// mac_port_control_zero fields
`define PPMC_MAC0_DUPLEX 6
`define PPMC_MAC0_TX_FC 5
`define PPMC_MAC0_RATE100 4
`define PPMC_MAC0_RX_FC 3
`define PPMC_MAC0_CLK3W 0
`define PPMC_MAC0_RW_MASK 8'h7F
`define PPMC_MAC0_RESET 8'h50

// mac_port_control_one fields (speed select and mii direction)
`define PPMC_MAC1_NOT_GIG 6
`define PPMC_MAC1_MAC_MODE 2
`define PPMC_MAC1_RW_MASK 8'h44
`define PPMC_MAC1_RESET 8'h00

// cycles after reset release before straps are taken
`define PPMC_STRAP_WAIT 2'h3

`endif

// ### ppmc_phy_port.v
// one integrated phy port: crossover and jabber/link result registers
`timescale 1ns/1ps
`include "ppmc_consts.vh"

module ppmc_phy_port (
    // clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // register writes
    input wire wr_xover,
    input wire wr_ctrl,
    input wire [15:0] wdata,
    // resolved link status from the phy core
    input wire link_resolved_pin,
    input wire [1:0] speed_code_pin,
    input wire duplex_pin,
    input wire master_pin,
    // register read values
    output wire [15:0] xover_rd,
    output wire [15:0] ctrl_rd,
    // phy controls
    output reg auto_xover_en,
    output reg forced_straight,
    output reg jabber_en
);

reg [15:0] xover;
reg [15:0] ctrl_rw;
reg [4:0] sync1;
reg [4:0] sync2;
reg [2:0] speed_onehot;
reg duplex_st;
reg master_st;
reg [2:0] next_speed_onehot;

// status comes from the phy core clock, so two flops first
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync1 <= 5'h00;
        sync2 <= 5'h00;
    end else if (ce) begin
        sync1 <= {link_resolved_pin, speed_code_pin, duplex_pin, master_pin};
        sync2 <= sync1;
    end
end

always @* begin
    next_speed_onehot = 3'h0;
    if (sync2[4]) begin
        case (sync2[3:2])
            `PPMC_SPD_CODE_10: next_speed_onehot = 3'h1;
            `PPMC_SPD_CODE_100: next_speed_onehot = 3'h2;
            `PPMC_SPD_CODE_1000: next_speed_onehot = 3'h4;
            default: next_speed_onehot = 3'h0;
        endcase
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        xover <= `PPMC_XOVER_RESET;
        ctrl_rw <= `PPMC_PHYCTL_RESET;
        speed_onehot <= 3'h0;
        duplex_st <= 1'b0;
        master_st <= 1'b0;
        auto_xover_en <= 1'b1;
        forced_straight <= 1'b0;
        jabber_en <= 1'b1;
    end else if (ce) begin
        if (wr_xover)
            xover <= wdata;
        if (wr_ctrl)
            ctrl_rw <= wdata & `PPMC_PHYCTL_RW_MASK;
        speed_onehot <= next_speed_onehot;
        duplex_st <= sync2[1];
        master_st <= sync2[0];
        auto_xover_en <= ~xover[`PPMC_XOVER_DISABLE];
        // forced mode only when auto off
        forced_straight <= xover[`PPMC_XOVER_DISABLE] &
            xover[`PPMC_XOVER_FORCED_STRAIGHT];
        jabber_en <= ctrl_rw[`PPMC_PHYCTL_JABBER];
    end
end

assign xover_rd = xover;
assign ctrl_rd = ctrl_rw |
    {9'h000, speed_onehot, duplex_st, master_st, 2'h0};

endmodule

// ### ppmc_top.v
// port phy and external mac port configuration registers on apb
//
// Operation
// - setting the crossover-disable bit 6 stops automatic crossover, clear (reset) lets it run.
// - with automatic crossover off, bit 7 one forces straight mdi and zero forces crossed mdi-x.
// - the forced-crossover bit is ignored while crossover-disable is zero.
// - phy_jabber_and_link_result bit 9 enables the jabber counter and resets to one.
// - read-only bits 6, 5, 4 report resolved 1000, 100 and 10 speed.
// - read-only bit 3 reports full duplex and bit 2 reports gigabit master.
// - mac control bit 6 selects full duplex when one, half when zero, reset one.
// - mac control bit 5 enables transmit flow control.
// - mac control bit 3 enables receive flow control.
// - flow-control and clock-mode reset values come from straps, not constants.
// - in non-gigabit mode mac control bit 4 picks 100 when one, 10 when zero, reset one.
// - the 10/100 bit is ignored while the companion register selects gigabit.
// - clock-mode bit 0 one puts the gigabit clock on the refout pin and mii clock on the error pin in mac mode.
// - clock-mode bit 0 zero uses the refout pin alone for gigabit or mii clock.
// - companion register bit 6 zero selects gigabit, one selects 10/100 per the speed bit.
`timescale 1ns/1ps
`include "ppmc_consts.vh"

module ppmc_top (
    // clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire pclk_en,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // configuration straps
    input wire flow_control_strap,
    input wire clock_mode_strap,
    input wire not_gig_strap,
    input wire mac_mode_strap,
    // resolved status from the five phy cores
    input wire [4:0] phy_link_resolved,
    input wire [9:0] phy_speed_code,
    input wire [4:0] phy_duplex,
    input wire [4:0] phy_master,
    // phy controls
    output wire [4:0] phy_auto_xover_en,
    output wire [4:0] phy_forced_straight,
    output wire [4:0] phy_jabber_en,
    // external mac interface controls
    output reg mac_full_duplex,
    output reg mac_tx_flow_en,
    output reg mac_rx_flow_en,
    output reg mac_rate_1000,
    output reg mac_rate_100,
    output reg mac_rate_10,
    // clock pin routing for port 6
    output reg port6_rx_clock_refout_pin_gtx,
    output reg port6_rx_clock_refout_pin_mii,
    output reg port6_rx_error_clock_pin_mii_in
);

reg [3:0] strap_s1;
reg [3:0] strap_s2;
reg [1:0] init_cnt;
reg init_done;
reg [7:0] mac_ctl0;
reg [7:0] mac_ctl1;
reg [31:0] next_prdata;
reg next_hit;
reg [4:0] wr_xover;
reg [4:0] wr_ctrl;
wire [79:0] xover_rd;
wire [79:0] ctrl_rd;
wire access;
wire commit;
wire in_port_space;
wire [3:0] port_sel;
wire [2:0] port_idx;
wire clk3w;
wire gig;

// a request is taken once the setup phase is over
assign access = psel & penable & ~pready & init_done;
// writes land on the edge where pready is seen high
assign commit = psel & penable & pready & pwrite;

assign port_sel = paddr[7:4];
assign port_idx = port_sel[2:0] - 3'h1;
assign in_port_space = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0) &&
    (port_sel >= 4'h1) && (port_sel <= 4'h5);

// straps arrive from pins, two flops before use
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        strap_s1 <= 4'h0;
        strap_s2 <= 4'h0;
    end else if (pclk_en) begin
        strap_s1 <= {flow_control_strap, clock_mode_strap,
            not_gig_strap, mac_mode_strap};
        strap_s2 <= strap_s1;
    end
end

// straps are caught after release, once the synchroniser has filled
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        init_cnt <= 2'h0;
        init_done <= 1'b0;
    end else if (pclk_en) begin
        if (init_cnt != `PPMC_STRAP_WAIT)
            init_cnt <= init_cnt + 2'h1;
        else
            init_done <= 1'b1;
    end
end

// per-port register write strobes
always @* begin : wr_decode
    integer i;
    i = 0;
    wr_xover = 5'h00;
    wr_ctrl = 5'h00;
    for (i = 0; i < `PPMC_NUM_PHY; i = i + 1) begin
        if (commit && in_port_space && port_idx == i[2:0]) begin
            wr_xover[i] = (paddr[3:0] == `PPMC_OFF_XOVER);
            wr_ctrl[i] = (paddr[3:0] == `PPMC_OFF_PHYCTL);
        end
    end
end

genvar g;
generate
    for (g = 0; g < `PPMC_NUM_PHY; g = g + 1) begin : phy
        ppmc_phy_port u_port (
            .pclk(pclk),
            .presetn(presetn),
            .ce(pclk_en),
            .wr_xover(wr_xover[g]),
            .wr_ctrl(wr_ctrl[g]),
            .wdata(pwdata[15:0]),
            .link_resolved_pin(phy_link_resolved[g]),
            .speed_code_pin(phy_speed_code[2*g+1:2*g]),
            .duplex_pin(phy_duplex[g]),
            .master_pin(phy_master[g]),
            .xover_rd(xover_rd[16*g+15:16*g]),
            .ctrl_rd(ctrl_rd[16*g+15:16*g]),
            .auto_xover_en(phy_auto_xover_en[g]),
            .forced_straight(phy_forced_straight[g]),
            .jabber_en(phy_jabber_en[g])
        );
    end
endgenerate

// mac port control registers
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mac_ctl0 <= `PPMC_MAC0_RESET;
        mac_ctl1 <= `PPMC_MAC1_RESET;
    end else if (pclk_en) begin
        if (!init_done && init_cnt == `PPMC_STRAP_WAIT) begin
            mac_ctl0[`PPMC_MAC0_TX_FC] <= strap_s2[3];
            mac_ctl0[`PPMC_MAC0_RX_FC] <= strap_s2[3];
            mac_ctl0[`PPMC_MAC0_CLK3W] <= strap_s2[2];
            mac_ctl1[`PPMC_MAC1_NOT_GIG] <= strap_s2[1];
            mac_ctl1[`PPMC_MAC1_MAC_MODE] <= strap_s2[0];
        end else if (commit && paddr == `PPMC_ADDR_MACCTL0) begin
            mac_ctl0 <= pwdata[7:0] & `PPMC_MAC0_RW_MASK;
        end else if (commit && paddr == `PPMC_ADDR_MACCTL1) begin
            mac_ctl1 <= pwdata[7:0] & `PPMC_MAC1_RW_MASK;
        end
    end
end

assign clk3w = mac_ctl0[`PPMC_MAC0_CLK3W];
assign gig = ~mac_ctl1[`PPMC_MAC1_NOT_GIG];

// mac interface controls, all registered
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mac_full_duplex <= 1'b1;
        mac_tx_flow_en <= 1'b0;
        mac_rx_flow_en <= 1'b0;
        mac_rate_1000 <= 1'b0;
        mac_rate_100 <= 1'b0;
        mac_rate_10 <= 1'b0;
        port6_rx_clock_refout_pin_gtx <= 1'b0;
        port6_rx_clock_refout_pin_mii <= 1'b0;
        port6_rx_error_clock_pin_mii_in <= 1'b0;
    end else if (pclk_en) begin
        mac_full_duplex <= mac_ctl0[`PPMC_MAC0_DUPLEX];
        mac_tx_flow_en <= mac_ctl0[`PPMC_MAC0_TX_FC];
        mac_rx_flow_en <= mac_ctl0[`PPMC_MAC0_RX_FC];
        mac_rate_1000 <= gig;
        mac_rate_100 <= ~gig & mac_ctl0[`PPMC_MAC0_RATE100];
        mac_rate_10 <= ~gig & ~mac_ctl0[`PPMC_MAC0_RATE100];
        if (clk3w) begin
            // separate pins for gigabit and mii clocks
            port6_rx_clock_refout_pin_gtx <= 1'b1;
            port6_rx_clock_refout_pin_mii <= 1'b0;
            port6_rx_error_clock_pin_mii_in <= mac_ctl1[`PPMC_MAC1_MAC_MODE];
        end else begin
            // shared refout pin follows the active rate
            port6_rx_clock_refout_pin_gtx <= gig;
            port6_rx_clock_refout_pin_mii <= ~gig;
            port6_rx_error_clock_pin_mii_in <= 1'b0;
        end
    end
end

// read mux, unmapped addresses answer with an error and zero data
always @* begin : rd_decode
    integer i;
    i = 0;
    next_prdata = 32'h00000000;
    next_hit = 1'b0;
    if (paddr == `PPMC_ADDR_MACCTL0) begin
        next_prdata = {24'h000000, mac_ctl0};
        next_hit = 1'b1;
    end else if (paddr == `PPMC_ADDR_MACCTL1) begin
        next_prdata = {24'h000000, mac_ctl1};
        next_hit = 1'b1;
    end else if (in_port_space) begin
        for (i = 0; i < `PPMC_NUM_PHY; i = i + 1) begin
            if (port_idx == i[2:0]) begin
                if (paddr[3:0] == `PPMC_OFF_XOVER) begin
                    next_prdata = {16'h0000, xover_rd[16*i +: 16]};
                    next_hit = 1'b1;
                end else if (paddr[3:0] == `PPMC_OFF_PHYCTL) begin
                    next_prdata = {16'h0000, ctrl_rd[16*i +: 16]};
                    next_hit = 1'b1;
                end
            end
        end
    end
end

// one wait state: pready rises the cycle after penable
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
    end else if (pclk_en) begin
        pready <= access;
        if (access) begin
            prdata <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= ~next_hit;
        end else begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end
end

endmodule

// ### ppmc_properties.sv
// concurrent checks on the ppmc apb answer and control outputs
`timescale 1ns/1ps
`include "ppmc_consts.vh"

module ppmc_properties (
    // clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire pclk_en,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    // controls
    input wire [4:0] phy_auto_xover_en,
    input wire [4:0] phy_forced_straight,
    input wire mac_full_duplex,
    input wire mac_tx_flow_en,
    input wire mac_rx_flow_en,
    input wire mac_rate_1000,
    input wire mac_rate_100,
    input wire mac_rate_10,
    input wire port6_rx_clock_refout_pin_gtx,
    input wire port6_rx_clock_refout_pin_mii,
    input wire port6_rx_error_clock_pin_mii_in
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // committed write to the mac control register
    wire wr0 = psel & penable & pready & pwrite & pclk_en &
        (paddr == `PPMC_ADDR_MACCTL0);
    wire gtx = port6_rx_clock_refout_pin_gtx;
    wire mii = port6_rx_clock_refout_pin_mii;

    a_xover_forced: assert property (
        (phy_forced_straight & phy_auto_xover_en) == 5'h00)
        else $error("forced straight while auto crossover on");
    a_duplex_write: assert property (
        wr0 |=> ##1 mac_full_duplex == $past(pwdata[6], 2))
        else $error("duplex output does not follow write");
    a_txfc_write: assert property (
        wr0 |=> ##1 mac_tx_flow_en == $past(pwdata[5], 2))
        else $error("tx flow output does not follow write");
    a_rxfc_write: assert property (
        wr0 |=> ##1 mac_rx_flow_en == $past(pwdata[3], 2))
        else $error("rx flow output does not follow write");
    a_rate_onehot: assert property (
        $onehot0({mac_rate_1000, mac_rate_100, mac_rate_10}))
        else $error("mac rate outputs not one-hot");
    a_gig_on_refout: assert property (
        mac_rate_1000 |-> gtx && !mii)
        else $error("gigabit rate without gtx on refout pin");
    a_refout_excl: assert property (!(gtx && mii))
        else $error("refout pin carries both clocks");
    a_mii_in_3w: assert property (
        port6_rx_error_clock_pin_mii_in |-> gtx && !mii)
        else $error("mii input clock pin used outside 3-wire");
    a_ready_pulse: assert property (pready && pclk_en |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (
        $rose(pready) |-> $past(psel && penable))
        else $error("pready without access phase");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
endmodule

bind ppmc_top ppmc_properties u_props (.pclk, .presetn, .pclk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .phy_auto_xover_en, .phy_forced_straight, .mac_full_duplex,
    .mac_tx_flow_en, .mac_rx_flow_en, .mac_rate_1000, .mac_rate_100,
    .mac_rate_10, .port6_rx_clock_refout_pin_gtx,
    .port6_rx_clock_refout_pin_mii, .port6_rx_error_clock_pin_mii_in);

// ### ppmc_tb_top.sv
// self-checking bench for the ppmc register block
`timescale 1ns/1ps
`include "ppmc_consts.vh"

module ppmc_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pclk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd, seed = 32'h00000050;
    logic pready, pslverr, err;
    logic fc_s = 1'b0, cm_s = 1'b0, ng_s = 1'b0, mm_s = 1'b0;
    logic [4:0] lres = 5'h00, dup = 5'h00, mst = 5'h00;
    logic [9:0] spd = 10'h000;
    logic [4:0] axo, fst, jab;
    logic fdx, txf, rxf, r1000, r100, r10, gtx, mii, miin;
    wire [31:0] mac_out = {23'h0, fdx, txf, rxf, r1000, r100, r10, gtx,
        mii, miin};
    int errors = 0;
    int checked = 0;

    ppmc_top dut (.pclk, .presetn, .pclk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .flow_control_strap(fc_s), .clock_mode_strap(cm_s),
        .not_gig_strap(ng_s), .mac_mode_strap(mm_s),
        .phy_link_resolved(lres), .phy_speed_code(spd), .phy_duplex(dup),
        .phy_master(mst), .phy_auto_xover_en(axo),
        .phy_forced_straight(fst), .phy_jabber_en(jab),
        .mac_full_duplex(fdx), .mac_tx_flow_en(txf), .mac_rx_flow_en(rxf),
        .mac_rate_1000(r1000), .mac_rate_100(r100), .mac_rate_10(r10),
        .port6_rx_clock_refout_pin_gtx(gtx),
        .port6_rx_clock_refout_pin_mii(mii),
        .port6_rx_error_clock_pin_mii_in(miin));

    always #4 pclk = ~pclk;

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [31:0] stat(int g);
        logic [1:0] c;
        c = spd[2*g +: 2];
        return {25'h0, lres[g] && c == 2'h2, lres[g] && c == 2'h1,
            lres[g] && c == 2'h0, dup[g], mst[g], 2'h0};
    endfunction

    // expected mac outputs from both control registers
    function automatic logic [31:0] mac_exp(logic [7:0] c0, logic [7:0] c1);
        logic g;
        g = !c1[6];
        return {23'h0, c0[6], c0[5], c0[3], g, !g && c0[4], !g && !c0[4],
            c0[0] || g, !c0[0] && !g, c0[0] && c1[2]};
    endfunction

    task automatic close_out();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; idle edge after it keeps drivers race-free
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!(pready === 1'b1 && pclk_en === 1'b1) && n < 40);
        // an answer only counts at an enabled edge
        if (!(pready === 1'b1 && pclk_en === 1'b1)) begin
            errors++;
            close_out();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic do_reset();
        logic [31:0] t;
        t = rnd();
        fc_s <= t[0];
        cm_s <= t[1];
        ng_s <= t[2];
        mm_s <= t[3];
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    initial begin
        logic [31:0] w, m, c1;
        for (int r = 0; r < 2; r++) begin
            do_reset();
            chk(32'(axo), 32'h1F);
            chk(32'(fst), 32'h0);
            chk(32'(jab), 32'h1F);
            m = {24'h0, 2'b01, fc_s, 1'b1, fc_s, 2'h0, cm_s};
            apb(1'b0, `PPMC_ADDR_MACCTL0, 32'h0);
            chk(rd, m);
            c1 = {25'h0, ng_s, 3'h0, mm_s, 2'h0};
            apb(1'b0, `PPMC_ADDR_MACCTL1, 32'h0);
            chk(rd, c1);
            chk(mac_out, mac_exp(m[7:0], c1[7:0]));
            for (int g = 0; g < 5; g++) begin
                apb(1'b0, 12'(16 * (g + 1)), 32'h0);
                chk(rd, 32'h0);
                apb(1'b0, 12'(16 * (g + 1) + 4), 32'h0);
                chk(rd, 32'h0300 | stat(g));
            end
        end
        $display("reset and strap test done");
        for (int g = 0; g < 5; g++) begin
            for (int k = 0; k < 4; k++) begin
                w = rnd();
                w[7:6] = k[1:0];
                apb(1'b1, 12'(16 * (g + 1)), w);
                apb(1'b0, 12'(16 * (g + 1)), 32'h0);
                chk(rd, w & 32'hFFFF);
                chk(32'(axo[g]), 32'(!w[6]));
                chk(32'(fst[g]), 32'(w[6] & w[7]));
            end
        end
        $display("crossover test done");
        for (int p = 0; p < 3; p++) begin
            w = rnd();
            lres <= w[4:0];
            dup <= w[9:5];
            mst <= w[14:10];
            spd <= w[24:15];
            repeat (6) @(posedge pclk);
            for (int g = 0; g < 5; g++) begin
                w = rnd();
                m = lres[g] ? 32'hFFFFFFFF : 32'hFFFFFFF3;
                apb(1'b1, 12'(16 * (g + 1) + 4), w);
                apb(1'b0, 12'(16 * (g + 1) + 4), 32'h0);
                chk(rd & m, ((w & 32'hF382) | stat(g)) & m);
                chk(32'(jab[g]), 32'(w[9]));
            end
        end
        $display("phy_jabber_and_link_result test done");
        // 3-wire outside mac mode is advice only, so it is still
        // driven here to keep the pin routing defined
        for (int k = 0; k < 16; k++) begin
            w = rnd();
            w[0] = k[0];
            w[4] = k[1];
            c1 = {25'h0, k[2], 3'h0, k[3], 2'h0};
            apb(1'b1, `PPMC_ADDR_MACCTL1, c1);
            apb(1'b1, `PPMC_ADDR_MACCTL0, w);
            apb(1'b0, `PPMC_ADDR_MACCTL0, 32'h0);
            chk(rd, w & 32'h7F);
            chk(mac_out, mac_exp(w[7:0], c1[7:0]));
        end
        $display("mac control test done");
        // freeze mid-transfer: the write must wait for an enabled edge
        w = rnd();
        fork
            apb(1'b1, `PPMC_ADDR_MACCTL0, w);
            begin
                repeat (2) @(posedge pclk);
                pclk_en <= 1'b0;
                repeat (5) @(posedge pclk);
                pclk_en <= 1'b1;
            end
        join
        apb(1'b0, `PPMC_ADDR_MACCTL0, 32'h0);
        chk(rd, w & 32'h7F);
        chk(mac_out, mac_exp(w[7:0], c1[7:0]));
        $display("clock enable test done");
        apb(1'b0, 12'h0FC, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 12'h200, 32'hFFFFFFFF);
        chk(32'(err), 32'h1);
        $display("unmapped access test done");
        close_out();
    end
endmodule
